// ---- logic/hcrst_pkg.sv ----
// Shared constants and carrier types for the host controller reset and clock-entry block.
// Assumes a single 20 MHz reference clock domain.
package hcrst_pkg;
	localparam int HCRST_CLK_PERIOD_NS = 50;
	// Reset release stretch after both sources deassert
	localparam int HCRST_RELEASE_NS = 500;
	localparam int HCRST_RELEASE_CYC = (HCRST_RELEASE_NS + HCRST_CLK_PERIOD_NS - 1)
		/ HCRST_CLK_PERIOD_NS;
	localparam logic HCRST_RST_ACTIVE_RESET = 1'b1;
	localparam logic HCRST_FREQ_SEL_RESET = 1'b0;
	// PLL multiplier codes, chosen by the frequency-select level
	localparam logic [7:0] HCRST_PLL_MULT_LOW = 8'h64;
	localparam logic [7:0] HCRST_PLL_MULT_HIGH = 8'h32;

	typedef enum {HCRST_HOLD, HCRST_STRETCH, HCRST_RUN} hcrst_state_t;

	typedef struct packed {
		logic internal_rst;
		logic func_enable;
		logic perst_por;
		logic [7:0] pll_mult;
		logic freq_sel_latched;
	} hcrst_out_t;
endpackage : hcrst_pkg

// ---- logic/hcrst_top.sv ----
// Reset and clock-entry logic: merges global power reset and the PCIe fundamental reset.
// Assumes both reset pins and the strap are asynchronous to ref_clk.
// What this block does
// - Global reset returns all registers to defaults
// - No function while global reset held
// - Strap level selects PLL multiplier; board low
// - Fundamental reset derives internal power-on reset
`timescale 1ns/1ps
module hcrst_top
	import hcrst_pkg::*;
#(
	parameter int RELEASE_CYC = HCRST_RELEASE_CYC
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Board pins
	input wire logic global_power_reset_n,
	input wire logic pcie_perst_n,
	input wire logic osc_freq_select,
	// Outputs
	output hcrst_out_t status
);
	localparam int CW = $clog2(RELEASE_CYC + 1);
	// Helper counter runs one step past the stretch
	localparam int HW = $clog2(RELEASE_CYC + 2);
	localparam logic [HW-1:0] RUN_MARK = HW'(RELEASE_CYC + 1);

	// Refused at elaboration: a zero stretch would release on the edge PERST is seen
	if (RELEASE_CYC < 1 || RELEASE_CYC > 4096) begin : g_bad_release
		$error("RELEASE_CYC out of range");
	end

	// Strap level to PLL multiplier; low is the normal board setting
	function automatic logic [7:0] mult_for(input logic sel);
		mult_for = sel ? HCRST_PLL_MULT_HIGH : HCRST_PLL_MULT_LOW;
	endfunction : mult_for

	// Raw async reset: either source asserted, held without a clock
	// Global reset skips the synchroniser so it clears flops with no clock running
	logic any_rst;
	assign any_rst = rst | ~global_power_reset_n;

	// Three-stage sampling of PERST# and strap
	logic [2:0] perst_sync_ff, nxt_perst_sync;
	logic [2:0] fsel_sync_ff, nxt_fsel_sync;
	logic perst_ok_ff, nxt_perst_ok;
	logic fsel_ok_ff, nxt_fsel_ok;
	logic [CW-1:0] cnt_ff, nxt_cnt;
	hcrst_state_t state_ff, nxt_state;
	hcrst_out_t out_ff, nxt_out;

	always_comb begin
		nxt_perst_sync = {perst_sync_ff[1:0], pcie_perst_n};
		nxt_fsel_sync = {fsel_sync_ff[1:0], osc_freq_select};
		nxt_perst_ok = perst_ok_ff;
		nxt_fsel_ok = fsel_ok_ff;
		// A change counts once stages two and three agree
		if (perst_sync_ff[1] == perst_sync_ff[2]) begin
			nxt_perst_ok = perst_sync_ff[2];
		end
		if (fsel_sync_ff[1] == fsel_sync_ff[2]) begin
			nxt_fsel_ok = fsel_sync_ff[2];
		end
	end

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_out = out_ff;
		case (state_ff)
			HCRST_HOLD: begin
				nxt_cnt = '0;
				if (perst_ok_ff) begin
					nxt_state = HCRST_STRETCH;
				end
			end
			HCRST_STRETCH: begin
				if (!perst_ok_ff) begin
					nxt_state = HCRST_HOLD;
				end else if (cnt_ff == CW'(RELEASE_CYC - 1)) begin
					nxt_state = HCRST_RUN;
				end else begin
					nxt_cnt = cnt_ff + CW'(1);
				end
			end
			HCRST_RUN: begin
				if (!perst_ok_ff) begin
					nxt_state = HCRST_HOLD;
				end
			end
			default: nxt_state = HCRST_HOLD;
		endcase
		nxt_out.perst_por = (nxt_state != HCRST_RUN);
		nxt_out.internal_rst = (nxt_state != HCRST_RUN);
		nxt_out.func_enable = (nxt_state == HCRST_RUN);
		// Strap is captured only while held in reset, so it cannot change the PLL mid-run
		if (nxt_state != HCRST_RUN) begin
			nxt_out.freq_sel_latched = fsel_ok_ff;
			nxt_out.pll_mult = mult_for(fsel_ok_ff);
		end
	end

	always_ff @(posedge ref_clk or posedge any_rst) begin
		if (any_rst) begin
			perst_sync_ff <= '0;
			fsel_sync_ff <= '0;
			perst_ok_ff <= 1'b0;
			fsel_ok_ff <= HCRST_FREQ_SEL_RESET;
			cnt_ff <= '0;
			state_ff <= HCRST_HOLD;
			out_ff.internal_rst <= HCRST_RST_ACTIVE_RESET;
			out_ff.perst_por <= HCRST_RST_ACTIVE_RESET;
			out_ff.func_enable <= 1'b0;
			out_ff.pll_mult <= HCRST_PLL_MULT_LOW;
			out_ff.freq_sel_latched <= HCRST_FREQ_SEL_RESET;
		end else begin
			perst_sync_ff <= nxt_perst_sync;
			fsel_sync_ff <= nxt_fsel_sync;
			perst_ok_ff <= nxt_perst_ok;
			fsel_ok_ff <= nxt_fsel_ok;
			cnt_ff <= nxt_cnt;
			state_ff <= nxt_state;
			out_ff <= nxt_out;
		end
	end

	assign status = out_ff;

	// Assertion helper: edges the filtered PERST level has stood high, saturating at
	// RUN_MARK so the release bound needs no long delay range
	logic [HW-1:0] ok_run_ff, nxt_ok_run;

	always_comb begin
		nxt_ok_run = ok_run_ff;
		if (!perst_ok_ff) begin
			nxt_ok_run = '0;
		end else if (ok_run_ff != RUN_MARK) begin
			nxt_ok_run = ok_run_ff + HW'(1);
		end
	end

	always_ff @(posedge ref_clk or posedge any_rst) begin
		if (any_rst) begin
			ok_run_ff <= '0;
		end else begin
			ok_run_ff <= nxt_ok_run;
		end
	end

	// Assertions
	sequence perst_seen_s;
		perst_ok_ff && state_ff == HCRST_HOLD;
	endsequence

	sequence stretch_open_s;
		perst_ok_ff && ok_run_ff != RUN_MARK;
	endsequence

	sequence stretch_done_s;
		perst_ok_ff && ok_run_ff == RUN_MARK;
	endsequence

	rst_and_en_a: assert property (@(posedge ref_clk) disable iff (any_rst)
		status.func_enable == !status.internal_rst)
		else $error("function enable not complement of reset");

	perst_drop_a: assert property (@(posedge ref_clk) disable iff (any_rst)
		$fell(perst_ok_ff) |=> status.internal_rst)
		else $error("PERST drop did not reset");

	release_delay_a: assert property (@(posedge ref_clk) disable iff (any_rst)
		stretch_open_s |-> status.internal_rst)
		else $error("reset released too early");

	release_bound_a: assert property (@(posedge ref_clk) disable iff (any_rst)
		stretch_done_s |-> !status.internal_rst && status.func_enable)
		else $error("reset not released after stretch");

	stretch_entry_a: assert property (@(posedge ref_clk) disable iff (any_rst)
		perst_seen_s |=> state_ff == HCRST_STRETCH && status.internal_rst)
		else $error("stretch not entered after PERST release");

	strap_hold_a: assert property (@(posedge ref_clk) disable iff (any_rst)
		!status.internal_rst && !$past(status.internal_rst) |-> $stable(status.pll_mult))
		else $error("PLL multiplier changed while running");

	strap_map_a: assert property (@(posedge ref_clk) disable iff (any_rst)
		status.pll_mult == mult_for(status.freq_sel_latched))
		else $error("PLL multiplier does not match strap");

	strap_capture_a: assert property (@(posedge ref_clk) disable iff (any_rst)
		status.internal_rst |-> status.freq_sel_latched == $past(fsel_ok_ff))
		else $error("strap not captured during reset");

	strap_filter_a: assert property (@(posedge ref_clk) disable iff (any_rst)
		fsel_sync_ff[1] != fsel_sync_ff[2] |=> $stable(fsel_ok_ff))
		else $error("strap level taken before stages agreed");

	sync_agree_a: assert property (@(posedge ref_clk) disable iff (any_rst)
		perst_sync_ff[1] == perst_sync_ff[2] |=> perst_ok_ff == $past(perst_sync_ff[2]))
		else $error("PERST level not taken after stages agreed");

	sync_hold_a: assert property (@(posedge ref_clk) disable iff (any_rst)
		perst_sync_ff[1] != perst_sync_ff[2] |=> $stable(perst_ok_ff))
		else $error("PERST level taken before stages agreed");

	por_match_a: assert property (@(posedge ref_clk) disable iff (any_rst)
		status.perst_por == status.internal_rst)
		else $error("power-on reset and internal reset disagree");

	hold_state_a: assert property (@(posedge ref_clk) disable iff (any_rst)
		state_ff == HCRST_HOLD |-> status.internal_rst && !status.func_enable)
		else $error("outputs active while held");

	run_gate_a: assert property (@(posedge ref_clk) disable iff (any_rst)
		state_ff != HCRST_RUN |-> !status.func_enable)
		else $error("function enabled outside run");
endmodule : hcrst_top

// ---- dv/hcrst_board_model.sv ----
// Board supervisor model: drives both reset pins and the frequency strap.
// Assumes the bench gives it commands on ref_clk rising edges.
`timescale 1ns/1ps
module hcrst_board_model (
	// Clock
	input wire logic ref_clk,
	// Commands
	input wire logic rails_ok,
	input wire logic clk_stable,
	input wire logic strap_high,
	input wire logic perst_rel,
	// Pins
	output logic global_power_reset_n,
	output logic pcie_perst_n,
	output logic osc_freq_select,
	// Reference clock pair
	output logic refclk_p,
	output logic refclk_n
);
	// Free-running 100 MHz pair for the link side; the block itself never samples it
	always begin
		refclk_p = 1'b0;
		#5;
		refclk_p = 1'b1;
		#5;
	end
	assign refclk_n = ~refclk_p;
	// Reset stays low until rails and reference clock are good
	always @(posedge ref_clk) begin
		global_power_reset_n <= rails_ok && clk_stable;
		pcie_perst_n <= perst_rel && rails_ok;
		osc_freq_select <= strap_high;
	end
endmodule : hcrst_board_model

// ---- dv/tb_hcrst_top.sv ----
// Self-checking bench for the reset and clock-entry block.
// Assumes the board model drives every pin; stretch shortened to 2 cycles.
`timescale 1ns/1ps
module tb_hcrst_top;
	import hcrst_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic rails_ok = 1'b0;
	logic strap_high = 1'b0;
	logic perst_rel = 1'b0;
	logic gpr_n, perst_n, fsel;
	logic refclk_p, refclk_n;
	hcrst_out_t status;
	int n_mismatch = 0;
	int check_count = 0;
	always #25 ref_clk = ~ref_clk;
	hcrst_board_model board (.ref_clk(ref_clk), .rails_ok(rails_ok), .clk_stable(rails_ok),
		.strap_high(strap_high), .perst_rel(perst_rel), .global_power_reset_n(gpr_n),
		.pcie_perst_n(perst_n), .osc_freq_select(fsel), .refclk_p(refclk_p),
		.refclk_n(refclk_n));
	hcrst_top #(.RELEASE_CYC(2)) uut (.ref_clk(ref_clk), .rst(rst),
		.global_power_reset_n(gpr_n), .pcie_perst_n(perst_n),
		.osc_freq_select(fsel), .status(status));
	function automatic hcrst_out_t st(input logic run, input logic [7:0] m, input logic fs);
		st = '{~run, run, ~run, m, fs};
	endfunction : st
	task automatic check(input logic [11:0] seen, input logic [11:0] want);
		check_count++;
		if (seen !== want) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : check
	task automatic complete_run;
		if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : complete_run
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick
	// Bounded wait for the internal reset to reach a level
	task automatic wait_rst(input logic lvl);
		int i;
		for (i = 0; i < 40 && status.internal_rst !== lvl; i++) tick(1);
		if (i == 40) begin
			n_mismatch++;
			complete_run();
		end
	endtask : wait_rst
	initial begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		tick(3);
		check(status, st(1'b0, HCRST_PLL_MULT_LOW, 1'b0));
		check({11'h0, refclk_p ^ refclk_n}, 12'h001);
		@(posedge ref_clk) rails_ok <= 1'b1;
		strap_high <= 1'b1;
		tick(10);
		check({9'h0, status[11:9]}, 12'h005);
		@(posedge ref_clk) perst_rel <= 1'b1;
		wait_rst(1'b0);
		check(status, st(1'b1, HCRST_PLL_MULT_HIGH, 1'b1));
		@(posedge ref_clk) strap_high <= 1'b0;
		tick(8);
		check(status, st(1'b1, HCRST_PLL_MULT_HIGH, 1'b1));
		@(posedge ref_clk) perst_rel <= 1'b0;
		wait_rst(1'b1);
		check({9'h0, status[11:9]}, 12'h005);
		@(posedge ref_clk) perst_rel <= 1'b1;
		wait_rst(1'b0);
		check(status, st(1'b1, HCRST_PLL_MULT_LOW, 1'b0));
		@(posedge ref_clk) rails_ok <= 1'b0;
		tick(1);
		check(status, st(1'b0, HCRST_PLL_MULT_LOW, 1'b0));
		complete_run();
	end
endmodule : tb_hcrst_top
